// ### verilog/rcl_frame_map.vh
// Offsets, field positions, codes and reset values of the frame engine.
`ifndef RCL_FRAME_MAP_VH
`define RCL_FRAME_MAP_VH
// ****************************************
// Frame bytes
// ****************************************
`define RCL_DELIM          8'h7E
`define RCL_ESC            8'h7D
`define RCL_ESC_XOR        8'h20
`define RCL_XON            8'h11
`define RCL_XOFF           8'h13
`define RCL_CSUM_GOOD      8'hFF
`define RCL_TYPE_REMOTE    8'h17
`define RCL_TYPE_REMOTE_RSP 8'h97
`define RCL_TYPE_LEGACY_RX 8'h80
`define RCL_OPT_APPLY_BIT  1
`define RCL_LEGACY_MODE    2'h2
// ****************************************
// Remote request positions, counted from the frame type byte
// ****************************************
`define RCL_RQ_TYPE        16'h0000
`define RCL_RQ_FID         16'h0001
`define RCL_RQ_DEST_LAST   16'h0009
`define RCL_RQ_OPTS        16'h000C
`define RCL_RQ_CMD_HI      16'h000D
`define RCL_RQ_CMD_LO      16'h000E
`define RCL_RQ_PARAM       16'h000F
`define RCL_RQ_MAX_LEN     16'h002F
// ****************************************
// Legacy receive frame positions, counted from the delimiter
// ****************************************
`define RCL_LX_LEN_HI      6'h01
`define RCL_LX_LEN_LO      6'h02
`define RCL_LX_TYPE        6'h03
`define RCL_LX_ADDR_LAST   6'h0B
`define RCL_LX_RSSI        6'h0C
`define RCL_LX_OPTS        6'h0D
`define RCL_LX_DATA        6'h0E
`define RCL_LX_HDR_LEN     16'h000B
// ****************************************
// Register offsets and reset values
// ****************************************
`define RCL_REG_CTRL       8'h00
`define RCL_REG_STAT       8'h04
`define RCL_REG_LASTREQ    8'h08
`define RCL_REG_PARAM_BASE 8'h40
`define RCL_CTRL_RESET     3'h0
`define RCL_MEM_DEPTH      6'h20
`endif

// ### verilog/rcl_byte_mem.v
// Byte memory with one write port and a registered read port.
module rcl_byte_mem (
  input  wire       mclk,
  input  wire       we,
  input  wire [4:0] waddr,
  input  wire [7:0] wdata,
  input  wire [4:0] raddr,
  output reg  [7:0] rdata
);
  reg [7:0] store [0:31];

  always @(posedge mclk) begin
    if (we) begin
      store[waddr] <= wdata;
    end
    rdata <= store[raddr];
  end
endmodule // rcl_byte_mem

// ### verilog/rcl_frame_engine.v
// Remote command request parser and legacy receive frame builder.
// How it works
// RULE1: A host frame is a remote configuration request when its type byte at offset 3 is 0x17.
// RULE2: The frame identifier at offset 4 is reported, and a zero identifier clears reqWantResp.
// RULE3: The host puts the 64-bit target address MSB first at 5-12, then 0xFFFE.
// RULE4: Bit value 0x02 of the options byte at offset 15 asks the target to apply at once.
// RULE5: The two-character command name sits at offsets 16-17.
// RULE6: Bytes from offset 18 are the value to write, and none at all make the request a read.
// RULE7: Each radio packet yields a 0x80 frame only while the output option equals 2.
// RULE8: The legacy frame carries the source address MSB first at 4-11 and payload from 14.
// RULE9: Offset 12 carries the magnitude of the negative dBm level as an unsigned byte.
// RULE10: Offset 13 holds ack in bit 0, broadcast in bit 1, delivery method in bits 7:6.
// RULE11: The checksum is 0xFF minus the byte sum from frame type through last payload byte.
// RULE12: With byte stuffing on, special bytes after the delimiter go out as 0x7D, value^0x20.
// RULE13: Frames start with 0x7E and a big-endian length from type through payload.
// RULE14: Frames with a bad checksum or length are dropped and parsing restarts at a delimiter.
//
// Our own choices: the register offsets and strobed register access.
`include "rcl_frame_map.vh"
module rcl_frame_engine (
  input  wire        mclk,
  input  wire        reset_n,
  input  wire [7:0]  regAddr,
  input  wire [31:0] regWdata,
  input  wire        regWr,
  input  wire        regRd,
  output wire [31:0] regRdata,
  input  wire [7:0]  hostByte,
  input  wire        hostValid,
  output reg         reqValid,
  output reg  [7:0]  reqFrameId,
  output reg         reqWantResp,
  output reg  [63:0] reqDest,
  output reg         reqApply,
  output reg  [15:0] reqCmd,
  output reg  [5:0]  reqParamLen,
  output reg         reqIsRead,
  input  wire [7:0]  rfByte,
  input  wire        rfByteValid,
  input  wire        rfDone,
  input  wire [63:0] rfSrcAddr,
  input  wire [7:0]  rfRssiMag,
  input  wire        rfAcked,
  input  wire        rfBroadcast,
  input  wire [1:0]  rfMethod,
  output wire        rfReady,
  output reg  [7:0]  txByte,
  output wire        txValid,
  input  wire        txReady
);
  // ****************************************
  // Shared helpers
  // ****************************************
  function isSpecial;
    input [7:0] b;
    begin
      isSpecial = (b == `RCL_DELIM) || (b == `RCL_ESC) || (b == `RCL_XON) || (b == `RCL_XOFF);
    end
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  reg  [1:0]  apiOutputOption;
  reg         byteStuffingOption;
  reg  [7:0]  rxGood;
  reg  [7:0]  rxBad;
  reg  [7:0]  txCount;
  reg  [7:0]  txDropped;
  reg  [31:0] rdHold;
  reg         rdFromMem;
  wire [7:0]  paramQ;
  wire        paramWin = (regAddr[7:6] == `RCL_REG_PARAM_BASE >> 6);

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      apiOutputOption    <= 2'h0;
      byteStuffingOption <= 1'b0;
      rdHold             <= 32'h0;
      rdFromMem          <= 1'b0;
    end else begin
      if (regWr && regAddr == `RCL_REG_CTRL) begin
        apiOutputOption    <= regWdata[1:0];
        byteStuffingOption <= regWdata[2];
      end
      rdFromMem <= regRd && paramWin;
      rdHold    <= 32'h0;
      if (regRd) begin
        case (regAddr)
          `RCL_REG_CTRL:    rdHold <= {29'h0, byteStuffingOption, apiOutputOption};
          `RCL_REG_STAT:    rdHold <= {txDropped, txCount, rxBad, rxGood};
          `RCL_REG_LASTREQ: rdHold <= {reqCmd, {2'h0, reqParamLen}, reqFrameId};
          default:          rdHold <= 32'h0;
        endcase
      end
    end
  end

  // Parameter bytes read back from the memory arrive one cycle late, like the registers.
  assign regRdata = rdFromMem ? {24'h0, paramQ} : rdHold;

  // ****************************************
  // Host frame parser
  // ****************************************
  localparam [4:0] P_HUNT = 5'h01;
  localparam [4:0] P_LENH = 5'h02;
  localparam [4:0] P_LENL = 5'h04;
  localparam [4:0] P_DATA = 5'h08;
  localparam [4:0] P_CSUM = 5'h10;

  reg  [4:0]  pState;
  reg  [15:0] pLen;
  reg  [15:0] pPos;
  reg  [7:0]  pSum;
  reg  [7:0]  pType;
  reg  [7:0]  pFid;
  reg  [63:0] pDest;
  reg  [7:0]  pOpts;
  reg  [15:0] pCmd;
  reg         escNext;
  wire        rawDelim = hostValid && hostByte == `RCL_DELIM;
  wire        resync   = rawDelim && byteStuffingOption; //RULE12
  wire        escLead  = hostValid && byteStuffingOption && hostByte == `RCL_ESC && !escNext;
  wire        take     = hostValid && !resync && !escLead && pState != P_HUNT;
  wire [7:0]  rxVal    = escNext ? (hostByte ^ `RCL_ESC_XOR) : hostByte; //RULE12
  wire [15:0] paramOff = pPos - `RCL_RQ_PARAM;
  wire        paramWe  = take && pState == P_DATA && pPos >= `RCL_RQ_PARAM
                         && pPos < `RCL_RQ_MAX_LEN;
  wire [7:0]  endSum   = pSum + rxVal;
  wire [15:0] paramCnt = pLen - `RCL_RQ_PARAM;
  wire        frameOk  = endSum == `RCL_CSUM_GOOD && pType == `RCL_TYPE_REMOTE
                         && pLen >= `RCL_RQ_PARAM && pLen <= `RCL_RQ_MAX_LEN;

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pState <= P_HUNT;
      pLen <= 16'h0;
      pPos <= 16'h0;
      pSum <= 8'h0;
      pType <= 8'h0;
      pFid <= 8'h0;
      pDest <= 64'h0;
      pOpts <= 8'h0;
      pCmd <= 16'h0;
      escNext <= 1'b0;
      rxGood <= 8'h0;
      rxBad <= 8'h0;
      reqValid <= 1'b0;
      reqFrameId <= 8'h0;
      reqWantResp <= 1'b0;
      reqDest <= 64'h0;
      reqApply <= 1'b0;
      reqCmd <= 16'h0;
      reqParamLen <= 6'h0;
      reqIsRead <= 1'b0;
    end else begin
      reqValid <= 1'b0;
      if (resync) begin
        if (pState != P_HUNT) begin
          rxBad <= rxBad + 8'h1; //RULE14
        end
        pState  <= P_LENH; //RULE14
        escNext <= 1'b0;
      end else if (escLead) begin
        escNext <= 1'b1;
      end else if (hostValid && pState == P_HUNT) begin
        if (rawDelim) begin
          pState <= P_LENH; //RULE13
        end
      end else if (take) begin
        escNext <= 1'b0;
        case (pState)
          P_LENH: begin
            pLen[15:8] <= rxVal; //RULE13
            pState <= P_LENL;
          end
          P_LENL: begin
            pLen[7:0] <= rxVal;
            pPos <= 16'h0;
            pSum <= 8'h0;
            pState <= ({pLen[15:8], rxVal} == 16'h0) ? P_HUNT : P_DATA;
          end
          P_DATA: begin
            pSum <= endSum; //RULE11
            pPos <= pPos + 16'h1;
            if (pPos == `RCL_RQ_TYPE) pType <= rxVal; //RULE1
            if (pPos == `RCL_RQ_FID) pFid <= rxVal; //RULE2
            if (pPos > `RCL_RQ_FID && pPos <= `RCL_RQ_DEST_LAST) begin
              pDest <= {pDest[55:0], rxVal}; //RULE3
            end
            if (pPos == `RCL_RQ_OPTS) pOpts <= rxVal; //RULE4
            if (pPos == `RCL_RQ_CMD_HI) pCmd[15:8] <= rxVal; //RULE5
            if (pPos == `RCL_RQ_CMD_LO) pCmd[7:0] <= rxVal; //RULE5
            if (pPos == pLen - 16'h1) pState <= P_CSUM;
          end
          P_CSUM: begin
            pState <= P_HUNT; //RULE14
            if (frameOk) begin
              rxGood      <= rxGood + 8'h1;
              reqValid    <= 1'b1; //RULE1
              reqFrameId  <= pFid;
              reqWantResp <= pFid != 8'h0; //RULE2
              reqDest     <= pDest; //RULE3
              reqApply    <= pOpts[`RCL_OPT_APPLY_BIT]; //RULE4
              reqCmd      <= pCmd; //RULE5
              reqParamLen <= paramCnt[5:0]; //RULE6
              reqIsRead   <= pLen == `RCL_RQ_PARAM; //RULE6
            end else begin
              rxBad <= rxBad + 8'h1; //RULE14
            end
          end
          default: pState <= P_HUNT;
        endcase
      end
    end
  end

  // A rejected frame may still overwrite the value bytes of the last good one.
  rcl_byte_mem uParamMem (
    .mclk  (mclk),
    .we    (paramWe), //RULE6
    .waddr (paramOff[4:0]),
    .wdata (rxVal),
    .raddr ({1'b0, regAddr[5:2]}),
    .rdata (paramQ)
  );

  // ****************************************
  // Legacy receive frame builder
  // ****************************************
  localparam [4:0] T_IDLE  = 5'h01;
  localparam [4:0] T_WAIT  = 5'h02;
  localparam [4:0] T_FETCH = 5'h04;
  localparam [4:0] T_SEND  = 5'h08;
  localparam [4:0] T_ESC   = 5'h10;

  reg  [4:0]  tState;
  reg  [5:0]  wrPtr;
  reg  [5:0]  tLen;
  reg  [5:0]  idx;
  reg  [7:0]  tSum;
  reg  [63:0] tAddr;
  reg  [7:0]  tRssi;
  reg  [7:0]  tOpts;
  reg  [7:0]  next_byte;
  wire [7:0]  payQ;
  wire [5:0]  lastIdx = `RCL_LX_DATA + tLen;
  wire [15:0] frameLen = `RCL_LX_HDR_LEN + {10'h0, tLen};
  wire [5:0]  payIdx  = idx - `RCL_LX_DATA;
  wire [5:0]  addrSh  = (`RCL_LX_ADDR_LAST - idx) << 3;

  assign rfReady = tState == T_IDLE;
  assign txValid = tState == T_SEND || tState == T_ESC;

  always @* begin
    next_byte = payQ; //RULE8
    if (idx == 6'h0) next_byte = `RCL_DELIM; //RULE13
    else if (idx == `RCL_LX_LEN_HI) next_byte = frameLen[15:8]; //RULE13
    else if (idx == `RCL_LX_LEN_LO) next_byte = frameLen[7:0];
    else if (idx == `RCL_LX_TYPE) next_byte = `RCL_TYPE_LEGACY_RX; //RULE7
    else if (idx <= `RCL_LX_ADDR_LAST) next_byte = tAddr[addrSh +: 8]; //RULE8
    else if (idx == `RCL_LX_RSSI) next_byte = tRssi; //RULE9
    else if (idx == `RCL_LX_OPTS) next_byte = tOpts; //RULE10
    else if (idx == lastIdx) next_byte = `RCL_CSUM_GOOD - tSum; //RULE11
  end

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tState <= T_IDLE;
      wrPtr <= 6'h0;
      tLen <= 6'h0;
      idx <= 6'h0;
      tSum <= 8'h0;
      tAddr <= 64'h0;
      tRssi <= 8'h0;
      tOpts <= 8'h0;
      txByte <= 8'h0;
      txCount <= 8'h0;
      txDropped <= 8'h0;
    end else begin
      case (tState)
        T_IDLE: begin
          if (rfByteValid && wrPtr < `RCL_MEM_DEPTH) begin
            wrPtr <= wrPtr + 6'h1;
          end
          if (rfDone) begin
            wrPtr <= 6'h0;
            if (apiOutputOption == `RCL_LEGACY_MODE) begin //RULE7
              tLen   <= wrPtr;
              tAddr  <= rfSrcAddr; //RULE8
              tRssi  <= rfRssiMag; //RULE9
              tOpts  <= {rfMethod, 4'h0, rfBroadcast, rfAcked}; //RULE10
              idx    <= 6'h0;
              tSum   <= 8'h0;
              tState <= T_WAIT;
            end else begin
              txDropped <= txDropped + 8'h1; //RULE7
            end
          end
        end
        // The payload memory answers a cycle after its address moves, hence the wait.
        T_WAIT: tState <= T_FETCH;
        T_FETCH: begin
          // The checksum byte is kept out of the sum so it stays steady while escaped.
          if (idx >= `RCL_LX_TYPE && idx != lastIdx) tSum <= tSum + next_byte; //RULE11
          if (idx != 6'h0 && byteStuffingOption && isSpecial(next_byte)) begin
            txByte <= `RCL_ESC; //RULE12
            tState <= T_ESC;
          end else begin
            txByte <= next_byte;
            tState <= T_SEND;
          end
        end
        T_ESC: begin
          if (txReady) begin
            txByte <= next_byte ^ `RCL_ESC_XOR; //RULE12
            tState <= T_SEND;
          end
        end
        T_SEND: begin
          if (txReady) begin
            if (idx == lastIdx) begin
              tState  <= T_IDLE;
              txCount <= txCount + 8'h1;
            end else begin
              idx    <= idx + 6'h1;
              tState <= T_WAIT;
            end
          end
        end
        default: tState <= T_IDLE;
      endcase
    end
  end

  // The read address only moves with idx, so the escaped byte is still on payQ in T_ESC.
  rcl_byte_mem uPayMem (
    .mclk  (mclk),
    .we    (rfByteValid && tState == T_IDLE && wrPtr < `RCL_MEM_DEPTH),
    .waddr (wrPtr[4:0]),
    .wdata (rfByte),
    .raddr (payIdx[4:0]),
    .rdata (payQ)
  );
endmodule // rcl_frame_engine

// ### dv/rcl_frame_props.sv
// Port checker of the frame engine.
module rcl_frame_props (
  input logic        mclk,
  input logic        reset_n,
  input logic [7:0]  regAddr,
  input logic [31:0] regWdata,
  input logic        regWr,
  input logic        regRd,
  input logic [31:0] regRdata,
  input logic        reqValid,
  input logic [7:0]  reqFrameId,
  input logic        reqWantResp,
  input logic [5:0]  reqParamLen,
  input logic        reqIsRead,
  input logic        rfDone,
  input logic        rfReady,
  input logic [7:0]  txByte,
  input logic        txValid,
  input logic        txReady
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] ctrl;
  // Shadow of the control register, so the checker knows the mode.
  always @(posedge mclk or negedge reset_n)
    if (!reset_n) ctrl <= 3'h0;
    else if (regWr && regAddr == 8'h00) ctrl <= regWdata[2:0];
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // ****
  // Assertions
  // ****
  a_tx_hold: assert property (txValid && !txReady |=> txValid && $stable(txByte))
    else $error("tx byte not held");
  a_rd_idle: assert property (!regRd |=> regRdata == 32'h0)
    else $error("read data outside read slot");
  a_want_resp: assert property (reqValid |-> reqWantResp == (reqFrameId != 8'h00))
    else $error("response flag wrong");
  a_read_kind: assert property (reqValid |-> reqIsRead == (reqParamLen == 6'h0))
    else $error("read flag wrong");
  a_req_pulse: assert property (reqValid |=> !reqValid)
    else $error("request pulse too long");
  a_mode_gate: assert property (rfDone && rfReady && ctrl[1:0] != 2'h2 |=> rfReady)
    else $error("frame built outside legacy mode");
  a_start_frame: assert property (rfDone && rfReady && ctrl[1:0] == 2'h2
    |=> !rfReady ##[1:4] txValid && txByte == 8'h7E)
    else $error("frame start missing");
  a_esc_pair: assert property (ctrl[2] && txValid && txReady && txByte == 8'h7D
    |=> ##[0:4] txValid && (txByte inside {8'h5E, 8'h5D, 8'h31, 8'h33}))
    else $error("escape not followed by coded byte");
endmodule // rcl_frame_props

bind rcl_frame_engine rcl_frame_props i_props (.mclk, .reset_n, .regAddr, .regWdata, .regWr,
  .regRd, .regRdata, .reqValid, .reqFrameId, .reqWantResp, .reqParamLen, .reqIsRead, .rfDone,
  .rfReady, .txByte, .txValid, .txReady);

// ### dv/rcl_host_model.sv
// Host model: sends request frames and sinks device frames.
module rcl_host_model (
  input  logic       mclk,
  input  logic [7:0] txByte,
  input  logic       txValid,
  input  logic       slow,
  output logic [7:0] hostByte,
  output logic       hostValid,
  output logic       txReady
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rxq[$];
  logic [1:0] tick = 2'h0;
  logic       esc = 1'b0;
  initial begin
    hostByte = 8'h00;
    hostValid = 1'b0;
    txReady = 1'b0;
  end
  // A slow host takes a byte only every fourth cycle, to stress the hold.
  always @(posedge mclk) begin
    tick <= tick + 2'h1;
    if (txValid && txReady) rxq.push_back(txByte);
    txReady <= !slow || tick == 2'h2;
  end
  task put(input logic [7:0] b);
    @(posedge mclk);
    hostByte <= b;
    hostValid <= 1'b1;
  endtask
  task putx(input logic [7:0] b);
    if (esc && b inside {8'h7E, 8'h7D, 8'h11, 8'h13}) begin
      put(8'h7D);
      put(b ^ 8'h20);
    end else put(b);
  endtask
  task req(input logic [7:0] fid, input logic [63:0] dest, input logic [7:0] opt,
           input logic [15:0] cmd, input int plen, input logic bad);
    logic [7:0] q[$];
    logic [7:0] sum;
    q = {8'h17, fid};
    for (int i = 7; i >= 0; i--) q.push_back(dest[8*i+:8]);
    q = {q, 8'hFF, 8'hFE, opt, cmd[15:8], cmd[7:0]};
    for (int i = 0; i < plen; i++) q.push_back(8'(i + 3));
    sum = 8'h00;
    put(8'h7E);
    putx(8'(q.size() >> 8));
    putx(8'(q.size()));
    foreach (q[i]) begin
      sum += q[i];
      putx(q[i]);
    end
    putx((8'hFF - sum) ^ {7'h0, bad});
    @(posedge mclk);
    hostValid <= 1'b0;
    hostByte <= ~hostByte;
  endtask
endmodule // rcl_host_model

// ### dv/tb_top.sv
// Testbench of the frame engine.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [7:0] fid; logic [63:0] dest; logic [7:0] opt; logic [15:0] cmd; int plen;
    logic [2:0] ctrl; logic want; logic apply; logic rd;
  } rcl_row_t;
  rcl_row_t rows[4] = '{
    '{8'h01, 64'h0013A20040401122, 8'h02, 16'h4248, 1, 3'h0, 1, 1, 0},
    '{8'h00, 64'h1122334455667788, 8'h00, 16'h4E49, 0, 3'h0, 0, 0, 1},
    '{8'h7E, 64'h7E7D111300000013, 8'h02, 16'h4944, 32, 3'h4, 1, 1, 0},
    '{8'h11, 64'h0, 8'h00, 16'h4143, 0, 3'h4, 1, 0, 1}};
  rcl_row_t   r;
  logic       mclk, reset_n, regWr, regRd, hostValid, reqValid, reqWantResp, reqApply;
  logic       reqIsRead, rfByteValid, rfDone, rfAcked, rfBroadcast, rfReady, txValid;
  logic       txReady, slow, stf, got;
  logic [7:0] regAddr, hostByte, reqFrameId, rfByte, rfRssiMag, txByte;
  logic [31:0] regWdata, regRdata, rd;
  logic [63:0] reqDest, rfSrcAddr;
  logic [15:0] reqCmd;
  logic [5:0] reqParamLen;
  logic [1:0] rfMethod;
  logic [7:0] exp[$];
  int         err_total = 0, samples_checked = 0, cyc = 0;
  rcl_frame_engine i_dut (.mclk, .reset_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .hostByte, .hostValid, .reqValid, .reqFrameId, .reqWantResp, .reqDest, .reqApply, .reqCmd,
    .reqParamLen, .reqIsRead, .rfByte, .rfByteValid, .rfDone, .rfSrcAddr, .rfRssiMag, .rfAcked,
    .rfBroadcast, .rfMethod, .rfReady, .txByte, .txValid, .txReady);
  rcl_host_model host (.mclk, .txByte, .txValid, .slow, .hostByte, .hostValid, .txReady);
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task finish_test;
    if (err_total == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      finish_test();
    end
  end
  task chk(input logic [63:0] s, input logic [63:0] e);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task regW(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample just past that edge.
  task regR(input logic [7:0] a);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 rd = regRdata;
  endtask
  // The pulse rises at the checksum edge the sender has just passed, so look before waiting.
  task waitReq;
    got = 1'b0;
    repeat (6) begin
      #1 if (reqValid === 1'b1) got = 1'b1;
      @(posedge mclk);
    end
  endtask
  task ex(input logic [7:0] b);
    if (stf && b inside {8'h7E, 8'h7D, 8'h11, 8'h13}) exp = {exp, 8'h7D, b ^ 8'h20};
    else exp.push_back(b);
  endtask
  task legacy(input logic [2:0] ctrl, input logic [63:0] a, input logic [7:0] rs,
              input logic [7:0] o, input int n);
    logic [7:0] q[$];
    logic [7:0] sum;
    regW(8'h00, {29'h0, ctrl});
    host.rxq = {};
    exp = {};
    stf = ctrl[2];
    slow <= !ctrl[2];
    sum = 8'h00;
    q = {8'h80};
    for (int i = 7; i >= 0; i--) q.push_back(a[8*i+:8]);
    q = {q, rs, o};
    for (int i = 0; i < n; i++) begin
      q.push_back(8'(i + 8'h11));
      @(posedge mclk);
      rfByte <= 8'(i + 8'h11);
      rfByteValid <= 1'b1;
    end
    @(posedge mclk);
    {rfByteValid, rfDone, rfSrcAddr, rfRssiMag} <= {1'b0, 1'b1, a, rs};
    {rfMethod, rfBroadcast, rfAcked} <= {o[7:6], o[1], o[0]};
    @(posedge mclk);
    rfDone <= 1'b0;
    exp.push_back(8'h7E);
    ex(8'(q.size() >> 8));
    ex(8'(q.size()));
    foreach (q[i]) begin
      sum += q[i];
      ex(q[i]);
    end
    ex(8'hFF - sum);
    if (ctrl[1:0] != 2'h2) exp = {};
    repeat (2) @(posedge mclk);
    for (int k = 0; k < 600 && !rfReady; k++) @(posedge mclk);
    chk(host.rxq.size(), exp.size());
    foreach (exp[i]) chk(host.rxq[i], exp[i]);
  endtask
  initial begin
    {regWr, regRd, rfByteValid, rfDone, rfAcked, rfBroadcast, slow, reset_n} = '0;
    {regAddr, rfByte, rfRssiMag, rfMethod, regWdata, rfSrcAddr} = '0;
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    foreach (rows[i]) begin
      r = rows[i];
      regW(8'h00, {29'h0, r.ctrl});
      host.esc = r.ctrl[2];
      host.req(r.fid, r.dest, r.opt, r.cmd, r.plen, 1'b0);
      waitReq();
      chk(got, 1);
      chk(reqFrameId, r.fid);
      chk(reqWantResp, r.want);
      chk(reqDest, r.dest);
      chk(reqApply, r.apply);
      chk(reqCmd, r.cmd);
      chk(reqIsRead, r.rd);
      chk(reqParamLen, r.plen);
    end
    regR(8'h40);
    chk(rd, 32'h3);
    regR(8'h7C);
    chk(rd, 32'h12);
    regR(8'h20);
    chk(rd, 32'h0);
    host.req(8'h01, 64'h0, 8'h00, 16'h4242, 0, 1'b1);
    waitReq();
    chk(got, 0);
    legacy(3'h2, 64'h0013A2004052C507, 8'h28, 8'h41, 6);
    legacy(3'h6, 64'h7E7D111300000001, 8'h40, 8'hC2, 3);
    legacy(3'h1, 64'h1, 8'h10, 8'h80, 2);
    regR(8'h04);
    chk(rd, 32'h01020104);
    reset_n <= 1'b0;
    @(posedge mclk);
    #1 chk({reqValid, txValid, rfReady, regRdata}, {3'b001, 32'h0});
    @(posedge mclk);
    reset_n <= 1'b1;
    regR(8'h04);
    chk(rd, 32'h0);
    regR(8'h08);
    chk(rd, 32'h0);
    finish_test();
  end
endmodule // tb_top
